// File: asp_pkg.sv
package asp_pkg;
  localparam logic [7:0] ASP_OFF_CTRL = 8'h00;
  localparam logic [7:0] ASP_OFF_BAUD = 8'h04;
  localparam logic [7:0] ASP_OFF_STAT = 8'h08;
  localparam logic [7:0] ASP_OFF_MASK = 8'h0c;
  localparam logic [7:0] ASP_OFF_TXD = 8'h10;
  localparam logic [7:0] ASP_OFF_RXD = 8'h14;
  // control fields
  localparam int ASP_CTRL_TXEN = 0;
  localparam int ASP_CTRL_RXEN = 1;
  localparam int ASP_CTRL_PEN = 2;
  localparam int ASP_CTRL_PODD = 3;
  localparam int ASP_CTRL_TRIPLE = 4;
  localparam int ASP_CTRL_LIN = 5;
  localparam int ASP_CTRL_W = 6;
  localparam logic [5:0] ASP_CTRL_RST = 6'h00;
  localparam logic [15:0] ASP_BAUD_RST = 16'h006c;
  // status fields (sticky, write one to clear)
  localparam int ASP_ST_RXF = 0;
  localparam int ASP_ST_FE = 1;
  localparam int ASP_ST_PE = 2;
  localparam int ASP_ST_NF = 3;
  localparam int ASP_ST_TBE = 4;
  localparam int ASP_ST_TC = 5;
  localparam int ASP_ST_W = 6;
  localparam logic [5:0] ASP_STAT_RST = 6'h00;
  localparam logic [5:0] ASP_MASK_RST = 6'h00;
  // oversampling: 16 ticks per bit, samples at 7,8,9
  localparam logic [3:0] ASP_OS_LAST = 4'hf;
  localparam logic [3:0] ASP_SMP_A = 4'h7;
  localparam logic [3:0] ASP_SMP_B = 4'h8;
  localparam logic [3:0] ASP_SMP_C = 4'h9;
  localparam logic [1:0] ASP_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_STOP} asp_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } asp_ahb_req_t;
  typedef struct packed {
    logic fe;
    logic pe;
    logic nf;
    logic [7:0] data;
  } asp_rx_res_t;
endpackage

// File: asp_async_serial_port.sv
`timescale 1ns/1ps
module asp_async_serial_port
  import asp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic txd_oe,
  output logic irq
);
  logic [5:0] ctrl_q;
  logic [15:0] baud_q;
  logic [5:0] stat_q;
  logic [5:0] mask_q;
  logic [7:0] rxdata_q;
  logic [7:0] txbuf_q;
  logic txbuf_full_q;
  asp_ahb_req_t req_q;
  logic req_valid_q;
  logic [15:0] div_q;
  logic tick;
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_line;
  logic [5:0] set_ev;
  logic wr_txd;
  logic wr_stat;
  logic rd_rxd;
  logic [31:0] rdata_d;
  logic wr_cfg;
  logic [5:0] ctrl_nx;
  logic [15:0] baud_nx;
  logic [5:0] mask_nx;
  logic [5:0] stat_nx;
  logic [7:0] txbuf_nx;
  logic [7:0] rxdata_nx;

  // bus address phase capture
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      req_valid_q <= 1'b0;
      req_q <= '0;
    end
    else if (hready)
    begin
      req_valid_q <= hsel && (htrans == ASP_HTRANS_NONSEQ);
      req_q.addr <= haddr[7:0];
      req_q.write <= hwrite;
    end
  end

  assign wr_txd = req_valid_q && req_q.write && (req_q.addr == ASP_OFF_TXD);
  assign wr_stat = req_valid_q && req_q.write && (req_q.addr == ASP_OFF_STAT);
  assign rd_rxd = req_valid_q && !req_q.write && (req_q.addr == ASP_OFF_RXD);

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= ASP_CTRL_RST;
      baud_q <= ASP_BAUD_RST;
      mask_q <= ASP_MASK_RST;
    end
    else
    begin
      ctrl_q <= ctrl_nx;
      baud_q <= baud_nx;
      mask_q <= mask_nx;
    end
  end
  assign wr_cfg = req_valid_q && req_q.write;
  assign ctrl_nx = (wr_cfg && (req_q.addr == ASP_OFF_CTRL)) ? hwdata[ASP_CTRL_W-1:0] : ctrl_q;
  assign baud_nx = (wr_cfg && (req_q.addr == ASP_OFF_BAUD)) ? hwdata[15:0] : baud_q;
  assign mask_nx = (wr_cfg && (req_q.addr == ASP_OFF_MASK)) ? hwdata[ASP_ST_W-1:0] : mask_q;

  // oversample tick divider: 16 ticks per bit
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (div_q >= baud_q))
      div_q <= 16'h0;
    else
      div_q <= div_q + 16'h1;
  end
  assign tick = (div_q >= baud_q);

  // pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= rxd_pin;
      rx_s2_q <= rx_s1_q;
    end
  end
  // in single-wire mode the receiver listens to the port's own drive
  assign rx_line = ctrl_q[ASP_CTRL_LIN] ? (txd_oe ? txd_pin : rx_s2_q) : rx_s2_q;

  // transmitter
  asp_state_t tx_st_q;
  logic [3:0] tx_os_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  logic tx_par_q;
  logic tx_load;
  logic tx_done;
  assign tx_load = (tx_st_q == ASP_IDLE) && txbuf_full_q && ctrl_q[ASP_CTRL_TXEN];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      txbuf_q <= 8'h0;
      txbuf_full_q <= 1'b0;
    end
    else if (wr_txd)
    begin
      txbuf_q <= hwdata[7:0];
      txbuf_full_q <= 1'b1;
    end
    else if (tx_load)
      txbuf_full_q <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tx_st_q <= ASP_IDLE;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
      tx_par_q <= 1'b0;
      txd_pin <= 1'b1;
      txd_oe <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_st_q <= ASP_START;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= {^txbuf_q ^ ctrl_q[ASP_CTRL_PODD], txbuf_q};
      tx_par_q <= ctrl_q[ASP_CTRL_PEN];
      txd_pin <= 1'b0;
      txd_oe <= 1'b1;
    end
    else if (tick && (tx_st_q != ASP_IDLE))
    begin
      tx_os_q <= tx_os_q + 4'h1;
      if (tx_os_q == ASP_OS_LAST)
      begin
        unique case (tx_st_q)
          ASP_START, ASP_DATA:
          begin
            if (tx_bit_q == (tx_par_q ? 4'h9 : 4'h8))
            begin
              tx_st_q <= ASP_STOP;
              txd_pin <= 1'b1;
            end
            else
            begin
              tx_st_q <= ASP_DATA;
              txd_pin <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
            end
          end
          ASP_STOP:
          begin
            tx_st_q <= ASP_IDLE;
            txd_oe <= 1'b0;
          end
          ASP_IDLE: tx_st_q <= ASP_IDLE;
        endcase
      end
    end
  end
  assign tx_done = tick && (tx_st_q == ASP_STOP) && (tx_os_q == ASP_OS_LAST);

  // receiver
  asp_state_t rx_st_q;
  logic [3:0] rx_os_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic [2:0] smp_q;
  logic rx_noise_q;
  logic rx_prev_q;
  logic bit_val;
  logic bit_end;
  logic rx_done;
  asp_rx_res_t rx_res;
  // majority vote or centre sample
  assign bit_val = ctrl_q[ASP_CTRL_TRIPLE] ? ((smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]))
                                           : smp_q[1];
  assign bit_end = tick && (rx_os_q == ASP_SMP_C + 4'h1);
  assign rx_done = bit_end && (rx_st_q == ASP_STOP);
  assign rx_res.data = rx_sh_q[7:0];
  assign rx_res.pe = ctrl_q[ASP_CTRL_PEN] && ((^rx_sh_q) ^ ctrl_q[ASP_CTRL_PODD]);
  assign rx_res.fe = !bit_val;
  assign rx_res.nf = ctrl_q[ASP_CTRL_TRIPLE] && (rx_noise_q || (smp_q != 3'b000 && smp_q != 3'b111));

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_st_q <= ASP_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h0;
      smp_q <= 3'h7;
      rx_noise_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rxdata_q <= 8'h0;
    end
    else if (tick)
    begin
      rx_prev_q <= rx_line;
      rx_os_q <= rx_os_q + 4'h1;
      if (rx_os_q == ASP_SMP_A)
        smp_q[0] <= rx_line;
      if (rx_os_q == ASP_SMP_B)
        smp_q[1] <= rx_line;
      if (rx_os_q == ASP_SMP_C)
        smp_q[2] <= rx_line;
      unique case (rx_st_q)
        ASP_IDLE:
        begin
          rx_os_q <= 4'h0;
          if (ctrl_q[ASP_CTRL_RXEN] && rx_prev_q && !rx_line)
          begin
            rx_st_q <= ASP_START;
            rx_os_q <= 4'h1;
            rx_noise_q <= 1'b0;
            rx_bit_q <= 4'h0;
          end
        end
        ASP_START, ASP_DATA:
        begin
          if (rx_os_q == ASP_OS_LAST)
            rx_os_q <= 4'h0;
          if (bit_end)
          begin
            rx_noise_q <= rx_res.nf;
            if (rx_st_q == ASP_START && bit_val)
              rx_st_q <= ASP_IDLE;
            else if (rx_st_q == ASP_START)
              rx_st_q <= ASP_DATA;
            else
            begin
              rx_sh_q <= ctrl_q[ASP_CTRL_PEN] ? {bit_val, rx_sh_q[8:1]} : {1'b0, bit_val, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == (ctrl_q[ASP_CTRL_PEN] ? 4'h8 : 4'h7))
                rx_st_q <= ASP_STOP;
            end
          end
        end
        ASP_STOP:
        begin
          if (bit_end)
          begin
            rx_st_q <= ASP_IDLE;
            rxdata_q <= rx_res.data;
          end
        end
      endcase
    end
  end

  // sticky status: hardware set wins over write-one clear
  assign set_ev[ASP_ST_RXF] = rx_done;
  assign set_ev[ASP_ST_FE] = rx_done && rx_res.fe;
  assign set_ev[ASP_ST_PE] = rx_done && rx_res.pe;
  assign set_ev[ASP_ST_NF] = rx_done && rx_res.nf;
  assign set_ev[ASP_ST_TBE] = tx_load;
  assign set_ev[ASP_ST_TC] = tx_done;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      stat_q <= ASP_STAT_RST;
    else
      stat_q <= stat_nx;
  end
  assign stat_nx = (stat_q & ~(wr_stat ? hwdata[ASP_ST_W-1:0] : 6'h0)) | set_ev;
  assign txbuf_nx = wr_txd ? hwdata[7:0] : txbuf_q;
  assign rxdata_nx = rx_done ? rx_res.data : rxdata_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(stat_nx & mask_nx);
  end

  // read mux on the address phase, fed with next values so a write just before is seen
  always_comb
  begin
    rdata_d = 32'h0;
    unique case (haddr[7:0])
      ASP_OFF_CTRL: rdata_d = {26'h0, ctrl_nx};
      ASP_OFF_BAUD: rdata_d = {16'h0, baud_nx};
      ASP_OFF_STAT: rdata_d = {26'h0, stat_nx};
      ASP_OFF_MASK: rdata_d = {26'h0, mask_nx};
      ASP_OFF_TXD: rdata_d = {24'h0, txbuf_nx};
      ASP_OFF_RXD: rdata_d = {24'h0, rxdata_nx};
      default: rdata_d = 32'h0;
    endcase
  end

  // read data registered at the address phase stands through the data phase
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && (htrans == ASP_HTRANS_NONSEQ) && !hwrite)
        hrdata <= rdata_d;
    end
  end

  logic unused_ok;
  assign unused_ok = rd_rxd ^ (|hsize) ^ (|haddr[31:8]);
endmodule

// File: asp_chk.sv
`timescale 1ns/1ps
module asp_chk
  import asp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd_pin,
  input wire logic txd_pin,
  input wire logic txd_oe,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_unmapped_zero: assert property (hsel && hready && htrans == ASP_HTRANS_NONSEQ && !hwrite
    && haddr[7:0] > ASP_OFF_RXD |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && !txd_oe && txd_pin && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  a_idle_high: assert property (!txd_oe |-> txd_pin)
    else $error("line not idle high");
  a_start_low: assert property ($rose(txd_oe) |-> !txd_pin)
    else $error("frame without start bit");
  a_frame_span: assert property ($rose(txd_oe) |=> txd_oe [*8])
    else $error("frame cut short");
  a_bit_hold: assert property ($changed(txd_pin) |=> $stable(txd_pin) [*8])
    else $error("serial bit too short");
endmodule
bind asp_async_serial_port asp_chk u_chk (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
  .hwdata, .hrdata, .hreadyout, .hresp, .rxd_pin, .txd_pin, .txd_oe, .irq);

// File: asp_node.sv
`timescale 1ns/1ps
module asp_node
(
  input wire logic sys_clk,
  input wire logic line,
  output logic drv
);
  localparam int BIT_CLKS = 16;
  initial drv = 1'b1;
  // one bit; a glitch flips a single clock in mid-bit
  task automatic put(input logic b, input logic gl);
    for (int i = 0; i < BIT_CLKS; i++)
    begin
      @(posedge sys_clk);
      drv <= b ^ (gl && i == 8);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic pen, input logic p, input logic stp, input logic gl);
    put(1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
      put(d[i], gl && i == 3);
    if (pen)
      put(p, 1'b0);
    put(stp, 1'b0);
    put(1'b1, 1'b0);
  endtask
  task automatic recv(output logic [8:0] v, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 4000 && !ok; n++)
    begin
      @(posedge sys_clk);
      ok = !line;
    end
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      v[i] = line;
    end
  endtask
endmodule

// File: async_serial_error_detect_test.sv
`timescale 1ns/1ps
module async_serial_error_detect_test
  import asp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, txd_pin, txd_oe, irq, drv, ok;
  logic [8:0] v;
  logic [7:0] d;
  int failures = 0;
  int checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  asp_async_serial_port dut (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .rxd_pin(drv), .txd_pin, .txd_oe, .irq);
  asp_node node (.sys_clk, .line(txd_oe ? txd_pin : 1'b1), .drv);
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        failures++;
        $display("MISMATCH %0t bus timeout", $time);
        end_of_test();
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= ASP_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(r & m, exp);
  endtask
  task automatic ic(input logic [7:0] a, input logic [31:0] wd, input logic e);
    bus(1'b1, a, wd);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(ASP_OFF_CTRL, 32'hffffffff, 32'h0);
    rc(ASP_OFF_BAUD, 32'hffffffff, {16'h0, ASP_BAUD_RST});
    bus(1'b1, 8'h18, 32'h5);
    rc(8'h18, 32'hffffffff, 32'h0);
    bus(1'b1, ASP_OFF_BAUD, 32'h0);
    rc(ASP_OFF_BAUD, 32'hffffffff, 32'h0);
    bus(1'b1, ASP_OFF_CTRL, 32'h3);
    rc(ASP_OFF_CTRL, 32'hffffffff, 32'h3);
    $display("test registers done");
    node.send(8'ha5, 1'b0, 1'b0, 1'b1, 1'b0);
    rc(ASP_OFF_RXD, 32'hff, 32'ha5);
    rc(ASP_OFF_STAT, 32'h3f, 32'h1);
    bus(1'b1, ASP_OFF_STAT, 32'h3f);
    node.send(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0);
    rc(ASP_OFF_STAT, 32'h2, 32'h2);
    $display("test framing done");
    for (int k = 0; k < 4; k++)
    begin
      d = 8'h5a ^ 8'(k);
      bus(1'b1, ASP_OFF_STAT, 32'h3f);
      bus(1'b1, ASP_OFF_CTRL, {28'h0, k[1], 3'h7});
      node.send(d, 1'b1, ^d ^ k[1] ^ k[0], 1'b1, 1'b0);
      rc(ASP_OFF_STAT, 32'h4, {29'h0, k[0], 2'h0});
      bus(1'b1, ASP_OFF_TXD, {24'h0, d});
      node.recv(v, ok);
      cmp({22'h0, ok, v}, {23'h1, ^d ^ k[1], d});
      repeat (32) @(posedge sys_clk);
    end
    $display("test parity done");
    bus(1'b1, ASP_OFF_STAT, 32'h3f);
    bus(1'b1, ASP_OFF_CTRL, 32'h13);
    node.send(8'hc3, 1'b0, 1'b0, 1'b1, 1'b1);
    rc(ASP_OFF_STAT, 32'h8, 32'h8);
    rc(ASP_OFF_RXD, 32'hff, 32'hc3);
    bus(1'b1, ASP_OFF_STAT, 32'h3f);
    bus(1'b1, ASP_OFF_CTRL, 32'h3);
    node.send(8'hc3, 1'b0, 1'b0, 1'b1, 1'b1);
    rc(ASP_OFF_STAT, 32'h8, 32'h0);
    rc(ASP_OFF_RXD, 32'hff, 32'hcb);
    $display("test noise done");
    bus(1'b1, ASP_OFF_STAT, 32'h3f);
    ic(ASP_OFF_MASK, 32'h30, 1'b0);
    bus(1'b1, ASP_OFF_TXD, 32'h81);
    rc(ASP_OFF_STAT, 32'h30, 32'h10);
    node.recv(v, ok);
    cmp({22'h0, ok, v}, {23'h1, 1'b1, 8'h81});
    repeat (32) @(posedge sys_clk);
    rc(ASP_OFF_STAT, 32'h31, 32'h30);
    ic(ASP_OFF_MASK, 32'h0, 1'b0);
    ic(ASP_OFF_MASK, 32'h30, 1'b1);
    ic(ASP_OFF_STAT, 32'h3f, 1'b0);
    $display("test transmit done");
    bus(1'b1, ASP_OFF_CTRL, 32'h23);
    bus(1'b1, ASP_OFF_TXD, 32'h96);
    node.recv(v, ok);
    cmp({22'h0, ok, v}, {23'h1, 1'b1, 8'h96});
    repeat (32) @(posedge sys_clk);
    rc(ASP_OFF_RXD, 32'hff, 32'h96);
    rc(ASP_OFF_STAT, 32'h1, 32'h1);
    $display("test echo done");
    end_of_test();
  end
endmodule
